// File: include/prpo_params.svh
`ifndef PRPO_PARAMS_SVH
`define PRPO_PARAMS_SVH

// power-up reset time in microseconds, longest allowed
`define PRPO_POWERUP_RESET_TIME_US 10
// core clock rate in MHz
`define PRPO_CLK_MHZ 50
// cycles for the power-up clear sweep (rounded down, at least one)
`define PRPO_POWERUP_CYCLES ((`PRPO_POWERUP_RESET_TIME_US * `PRPO_CLK_MHZ) < 1 ? 1 : \
    (`PRPO_POWERUP_RESET_TIME_US * `PRPO_CLK_MHZ))
// register count default
`define PRPO_NUM_REGS 8
// test-entry key, value arbitrary
`define PRPO_ENTRY_KEY 8'ha5
// mode codes on the test command pins
`define PRPO_CMD_PRELOAD 2'h1
`define PRPO_CMD_OBSERVE 2'h2
`define PRPO_CMD_EXIT 2'h3

`endif

// File: include/prpo_pkg.sv
package prpo_pkg;
    // test mode state, gray codes along init -> run -> preload -> observe
    typedef enum logic [1:0] {
        PRPO_INIT = 2'b00,
        PRPO_RUN = 2'b01,
        PRPO_PRELOAD = 2'b11,
        PRPO_OBSERVE = 2'b10
    } prpo_mode_t;
endpackage

// File: hdl/prpo_cell.sv
`timescale 1ns/1ps
`include "prpo_params.svh"

// one macrocell register: power-up clear, pin preload and clock-enabled function input
module prpo_cell (
    input wire logic clk, // core clock
    input wire logic reset, // synchronous reset, high
    input wire logic clear, // power-up clear
    input wire logic load, // preload from pin
    input wire logic pin_in, // pin value for preload
    input wire logic d_in, // product-term sum
    input wire logic func_en, // normal clock enable
    output logic q // register content
);
    logic next_q;

    // register next value: clear beats load beats function
    always_comb begin
        next_q = q;
        if (clear) begin
            next_q = 1'b0;
        end else if (load) begin
            next_q = pin_in;
        end else if (func_en) begin
            next_q = d_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q <= 1'b0;
        end else begin
            q <= next_q;
        end
    end
endmodule // prpo_cell

// File: hdl/prpo_core.sv
`timescale 1ns/1ps
`include "prpo_params.svh"

module prpo_core
    import prpo_pkg::*;
#(
    parameter int NUM_REGS = `PRPO_NUM_REGS, // macrocell count
    parameter int POWERUP_CYCLES = `PRPO_POWERUP_CYCLES // clear sweep length
) (
    input wire logic CORE_CLK, // core clock
    input wire logic RESET, // synchronous reset, high
    input wire logic [NUM_REGS-1:0] PIN_IN, // pin input levels
    input wire logic [NUM_REGS-1:0] TERM_IN, // product-term sums from the array
    input wire logic [NUM_REGS-1:0] COMB_CFG, // 1 = combinatorial output
    input wire logic [NUM_REGS-1:0] POL_CFG, // 1 = invert output
    input wire logic [NUM_REGS-1:0] OE_FUNC, // functional output enables
    input wire logic CLK_EN, // functional register clock enable
    input wire logic [7:0] TEST_KEY, // test-entry key
    input wire logic [1:0] TEST_CMD, // test command
    input wire logic TEST_STB, // one-cycle command strobe
    output logic [NUM_REGS-1:0] PIN_OUT, // pin output levels
    output logic [NUM_REGS-1:0] PIN_OE, // pin drive enables, high drives
    output logic [NUM_REGS-1:0] REG_Q, // register contents to the array feedback
    output logic TEST_ACTIVE, // preload or observe in progress
    output logic INIT_DONE // power-up clear finished
);
    import prpo_pkg::*;

    // refuse sizes that the counters and vectors cannot serve
    if (NUM_REGS < 1 || NUM_REGS > 256) begin : g_bad_regs
        $error("NUM_REGS out of range");
    end
    if (POWERUP_CYCLES < 1) begin : g_bad_sweep
        $error("POWERUP_CYCLES must be positive");
    end
    // a longer sweep would overrun the power-up reset time
    if (POWERUP_CYCLES > `PRPO_POWERUP_RESET_TIME_US * `PRPO_CLK_MHZ) begin : g_long_sweep
        $error("POWERUP_CYCLES exceeds the power-up reset time");
    end

    localparam int CW = $clog2(POWERUP_CYCLES + 1);

    // =========================================================
    // mode control
    prpo_mode_t mode, next_mode;
    logic [CW-1:0] init_cnt, next_init_cnt;
    logic key_ok;

    assign key_ok = TEST_STB && (TEST_KEY == `PRPO_ENTRY_KEY);

    // keyed command steps between run, preload and observe
    always_comb begin
        next_mode = mode;
        next_init_cnt = init_cnt;
        unique case (mode)
            PRPO_INIT: begin
                // counts the sweep; cleared cells are held low throughout
                if (init_cnt == CW'(POWERUP_CYCLES - 1)) begin
                    next_mode = PRPO_RUN;
                end else begin
                    next_init_cnt = init_cnt + CW'(1);
                end
            end
            PRPO_RUN, PRPO_PRELOAD, PRPO_OBSERVE: begin
                if (key_ok) begin
                    if (TEST_CMD == `PRPO_CMD_PRELOAD) begin
                        next_mode = PRPO_PRELOAD;
                    end else if (TEST_CMD == `PRPO_CMD_OBSERVE) begin
                        next_mode = PRPO_OBSERVE;
                    end else if (TEST_CMD == `PRPO_CMD_EXIT) begin
                        next_mode = PRPO_RUN;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            mode <= PRPO_INIT;
            init_cnt <= '0;
        end else begin
            mode <= next_mode;
            init_cnt <= next_init_cnt;
        end
    end

    // =========================================================
    // macrocells
    logic [NUM_REGS-1:0] q;
    logic clearing, loading, testing, run_en;

    assign clearing = (mode == PRPO_INIT);
    assign loading = (mode == PRPO_PRELOAD);
    assign testing = (mode == PRPO_PRELOAD) || (mode == PRPO_OBSERVE);
    // registers hold during observe so the tester sees stable data
    assign run_en = (mode == PRPO_RUN) && CLK_EN;

    for (genvar i = 0; i < NUM_REGS; i++) begin : g_cell
        logic d_sel;
        // combinatorial cells feed zero into the register while testing
        assign d_sel = (COMB_CFG[i] && testing) ? 1'b0 : TERM_IN[i];
        prpo_cell u_cell (
            .clk(CORE_CLK),
            .reset(RESET),
            .clear(clearing),
            .load(loading),
            .pin_in(PIN_IN[i]),
            .d_in(d_sel),
            .func_en(run_en),
            .q(q[i])
        );
    end

    // =========================================================
    // output stage, registered so pins come from flip-flops
    logic [NUM_REGS-1:0] next_pin_out, next_pin_oe;
    logic next_active, next_done;

    // a combinatorial cell shows TERM_IN only outside test; one cycle of latency
    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            if (COMB_CFG[k] && !testing && !clearing) begin
                next_pin_out[k] = TERM_IN[k] ^ POL_CFG[k];
            end else begin
                next_pin_out[k] = q[k] ^ POL_CFG[k];
            end
        end
        // preload needs the pins free for the tester
        if (mode == PRPO_OBSERVE) begin
            next_pin_oe = '1;
        end else if (mode == PRPO_RUN) begin
            next_pin_oe = OE_FUNC;
        end else begin
            next_pin_oe = '0;
        end
        next_active = testing;
        next_done = (mode != PRPO_INIT);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
            REG_Q <= '0;
            TEST_ACTIVE <= 1'b0;
            INIT_DONE <= 1'b0;
        end else begin
            PIN_OUT <= next_pin_out;
            PIN_OE <= next_pin_oe;
            REG_Q <= q;
            TEST_ACTIVE <= next_active;
            INIT_DONE <= next_done;
        end
    end

    // =========================================================
    // checks
    // cycles since reset release, saturating; one bit wider than the sweep counter so the bound always fits
    logic [CW:0] since_rst, next_since_rst;

    always_comb begin
        next_since_rst = since_rst;
        if (since_rst != '1) begin
            next_since_rst = since_rst + (CW+1)'(1);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            since_rst <= '0;
        end else begin
            since_rst <= next_since_rst;
        end
    end

    // one property per device-side rule; reset disables every check

    a_clear_low: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_INIT) |=> (q == '0)) else $error("register not cleared during power-up");
    a_init_bound: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (since_rst > (CW+1)'(POWERUP_CYCLES)) |-> INIT_DONE) else $error("power-up clear too long");
    a_init_quiet: assert property (@(posedge CORE_CLK) disable iff (RESET)
        clearing |=> (PIN_OE == '0) && !TEST_ACTIVE) else $error("pins driven during power-up clear");
    a_preload_loads: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_PRELOAD) |=> (q == $past(PIN_IN))) else $error("preload did not load pins");
    a_observe_drive: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_OBSERVE) |=> (PIN_OE == '1) && (PIN_OUT == ($past(q) ^ $past(POL_CFG))))
        else $error("observe did not drive register contents");
    a_comb_forced: assert property (@(posedge CORE_CLK) disable iff (RESET)
        testing |=> (PIN_OUT == ($past(q) ^ $past(POL_CFG)))) else $error("comb output not registered in test");
    a_comb_restore: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_RUN) && (COMB_CFG[0]) |=> (PIN_OUT[0] == ($past(TERM_IN[0]) ^ $past(POL_CFG[0]))))
        else $error("comb output not restored");
    // the exit edge of a preload is still a preload edge, so the pins land there once more
    a_exit_keeps: assert property (@(posedge CORE_CLK) disable iff (RESET)
        testing && key_ok && (TEST_CMD == `PRPO_CMD_EXIT) |=> (mode == PRPO_RUN) &&
        (q == (($past(mode) == PRPO_PRELOAD) ? $past(PIN_IN) : $past(q))))
        else $error("exit lost contents");
    a_no_stray_entry: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_RUN) && !key_ok |=> (mode == PRPO_RUN)) else $error("test mode entered without key");

    a_observe_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_OBSERVE) |=> (q == $past(q))) else $error("register changed during observe");
    a_preload_float: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_PRELOAD) |=> (PIN_OE == '0)) else $error("pins driven during preload");
    a_run_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_RUN) && !CLK_EN |=> (q == $past(q))) else $error("register moved without clock enable");
    a_terms_zero: assert property (@(posedge CORE_CLK) disable iff (RESET)
        testing && COMB_CFG[0] |-> (g_cell[0].d_sel == 1'b0)) else $error("product terms not held at zero");

    // main scenarios: preload and observe reached, direct preload to observe, and the way back
    c_preload: cover property (@(posedge CORE_CLK) disable iff (RESET) mode == PRPO_PRELOAD);
    c_direct_observe: cover property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_PRELOAD) ##1 (mode == PRPO_OBSERVE));
    c_observe: cover property (@(posedge CORE_CLK) disable iff (RESET) mode == PRPO_OBSERVE);
    c_back_run: cover property (@(posedge CORE_CLK) disable iff (RESET)
        (mode == PRPO_OBSERVE) ##1 (mode == PRPO_RUN));
endmodule // prpo_core

// File: test/prpo_tester.sv
`timescale 1ns/1ps
// ==========
// external tester: keyed commands and pin drive
module prpo_tester (
    input wire logic clk, // core clock
    output logic [7:0] key, // test-entry key
    output logic [1:0] cmd, // test command
    output logic stb, // command strobe
    output logic [7:0] pin_drv // levels driven onto the pins
);
    // quiet lines at start; no latches are built, so none needs restoring
    initial begin
        key = 8'h00;
        cmd = 2'h0;
        stb = 1'b0;
        pin_drv = 8'h00; // preload states never assert a reset or preset line
    end
    // pin levels offered for preload; called just after a clock edge
    task automatic drive(input logic [7:0] v);
        pin_drv <= v;
    endtask
    // one-cycle keyed strobe; the key is spoiled after so no stale match lingers
    task automatic send(input logic [7:0] k, input logic [1:0] c);
        @(posedge clk);
        key <= k;
        cmd <= c;
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
        key <= ~k;
    endtask
endmodule // prpo_tester

// File: test/test_powerup_reset_preload_observe.sv
`timescale 1ns/1ps
// ==========
// bench for power-up clear, preload and observe
module test_powerup_reset_preload_observe;
    localparam logic [7:0] POL = 8'h5a;
    localparam logic [7:0] COMB = 8'h0f;
    localparam logic [7:0] OEF = 8'h33;
    localparam int PU = 4;
    logic clk, rst, clk_en, stb, active, done;
    logic [7:0] term, pin_drv, pin_wire, pin_out, pin_oe, reg_q, key;
    logic [1:0] cmd;
    int mismatches = 0, n_checks = 0, cycles = 0;
    // pin level: the device wins where it drives, the tester elsewhere
    assign pin_wire = (pin_oe & pin_out) | (~pin_oe & pin_drv);
    prpo_core #(.NUM_REGS(8), .POWERUP_CYCLES(PU)) u_dut (.CORE_CLK(clk), .RESET(rst), .PIN_IN(pin_wire),
        .TERM_IN(term), .COMB_CFG(COMB), .POL_CFG(POL), .OE_FUNC(OEF), .CLK_EN(clk_en), .TEST_KEY(key),
        .TEST_CMD(cmd), .TEST_STB(stb), .PIN_OUT(pin_out), .PIN_OE(pin_oe), .REG_Q(reg_q),
        .TEST_ACTIVE(active), .INIT_DONE(done));
    prpo_tester u_tester (.clk(clk), .key(key), .cmd(cmd), .stb(stb), .pin_drv(pin_drv));
    // ==========
    // clock and hang guard; the whole run needs well under a hundred cycles
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // reset for 11 edges, then time the clear sweep; clock enable stays low until it ends
    task automatic t_powerup;
        int n;
        n = 0;
        @(posedge clk);
        rst <= 1'b1;
        clk_en <= 1'b0;
        term <= 8'h00;
        tick(10);
        check(reg_q, 8'h00);
        check({7'h00, done}, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        while (done !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check(8'(n), 8'(PU + 1));
        tick(2);
        check(reg_q, 8'h00);
        check(pin_out, POL);
        check({7'h00, active}, 8'h00);
        $display("powerup done");
    endtask
    // preload, then observe straight after, with comb cells forced registered
    task automatic t_preload_observe;
        @(posedge clk);
        term <= 8'hff;
        u_tester.drive(8'h3c);
        u_tester.send(8'ha5, 2'h1);
        tick(3);
        check(reg_q, 8'h3c);
        check(pin_oe, 8'h00);
        check(pin_out, 8'h3c ^ POL);
        u_tester.send(8'ha5, 2'h2);
        // new pin levels only once observe is taken, so the device must win on the pins
        u_tester.drive(8'hc3);
        tick(3);
        check(pin_oe, 8'hff);
        check(reg_q, 8'h3c);
        check(pin_out, 8'h3c ^ POL);
        check(pin_wire, 8'h3c ^ POL);
        $display("preload observe done");
    endtask
    // refused commands, exit, then normal clocking from kept contents
    task automatic t_exit;
        u_tester.send(8'h5a, 2'h3);
        u_tester.send(8'ha5, 2'h0);
        tick(2);
        check({7'h00, active}, 8'h01);
        u_tester.send(8'ha5, 2'h3);
        tick(3);
        check({7'h00, active}, 8'h00);
        check(reg_q, 8'h3c);
        check(pin_oe, OEF);
        check(pin_out, ((term & COMB) | (8'h3c & ~COMB)) ^ POL);
        @(posedge clk);
        clk_en <= 1'b1;
        term <= 8'h96;
        tick(3);
        check(reg_q, 8'h96);
        $display("exit done");
    endtask
    initial begin
        rst = 1'b1;
        clk_en = 1'b0;
        term = 8'h00;
        t_powerup();
        t_preload_observe();
        t_exit();
        t_powerup();
        final_report();
    end
endmodule // test_powerup_reset_preload_observe
